// ---- hw/pmsc_startup_top.sv ----
/*
  start-up sequence, voltage code decode, phase mode selection and an
  avalon-mm register slave of a two-phase buck controller.
  assumes asynchronous pins and comparator results as digital levels.
*/
// The Avalon-MM slave port and the address map were chosen for this implementation.
// Contract
// - enable input high starts start-up sequence
// - boot ramp begins about 100 us later
// - start-up forces two-phase ccm, ignores inputs
// - boot ramp charges soft at 41 ua
// - 13 in-window cycles: clock enable low, 200ua
// - slew to code, power ok 7 ms later
// - code decodes 1.5 v down, 12.5 mv steps
// - sleep and deep stop pick dcm, else load
// - one-phase ccm holds phase 2 gates off
// - dcm: phase 2 off, lower gate off at zero
// - sense tied high: phase 2 off, diode emulation
// - single-phase entry waits for voltage ramp end
// - code change in dcm returns two-phase ccm
// - under two periods never idles a phase
// - under seven periods never enters dcm
// - two-phase channels run 180 degrees apart
// - shift current, see zero, then idle phase
`timescale 1ns/1ps
module pmsc_startup_top #(
  parameter int BOOT_DELAY = pmsc_pkg::BOOT_DELAY_CYC,
  parameter int POWER_OK_DELAY = pmsc_pkg::POWER_OK_DELAY_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic REGULATOR_ON_INPUT,
  input wire logic SLEEP_VR_REQUEST,
  input wire logic DEEP_STOP_N,
  input wire logic LOW_LOAD_INDICATE_N,
  input wire logic [6:0] VOLTAGE_CODE,
  input wire logic PHASE_TWO_CURRENT_SENSE,
  input wire logic VOUT_IN_BOOT_WINDOW,
  input wire logic VOUT_SETTLED,
  input wire logic PHASE_ONE_ZERO_CURRENT,
  input wire logic PHASE_TWO_ZERO_CURRENT,
  output logic SYS_CLOCK_EN_N,
  output logic POWER_OK,
  output logic SOFT_RAMP_EN,
  output logic SOFT_SRC_LOW,
  output logic SOFT_SRC_HIGH,
  output logic [15:0] TARGET_TENTH_MV,
  output logic FB2_SWITCH_CLOSED,
  output logic UGATE1,
  output logic LGATE1,
  output logic UGATE2,
  output logic LGATE2
);
  // two-stage synchronisers for every pin but the avalon bus
  localparam int NSYNC = 16;
  logic [NSYNC-1:0] pin_raw; // gathered pins
  logic [NSYNC-1:0] sync1_r; // first stage, read only by the second
  logic [NSYNC-1:0] sync2_r; // second stage, safe to use
  logic reg_on, sleep_req, deep_n, low_load_n, ph2_tied, in_window, settled, ph1_zero, ph2_zero;
  logic [6:0] vcode; // synchronised voltage code, bit 0 lsb

  // state
  pmsc_pkg::pmsc_boot_t boot_r, boot_nxt; // start-up sequence state
  pmsc_pkg::pmsc_mode_t mode_r, mode_nxt; // phase operation mode
  logic [pmsc_pkg::DLY_W-1:0] dly_r; // start-up delay counter
  logic [3:0] qual_r; // consecutive in-window switching cycles
  logic one_only_r; // single-phase-only strap, caught while off
  logic [6:0] vcode_last_r; // code seen last cycle
  logic code_chg; // code changed this cycle
  logic ramp_busy_r; // output still slewing to a new code
  logic [15:0] period_r; // software switching period
  logic [15:0] ontime_r; // software on time
  logic [2:0] combo; // {sleep, deep_n, low_load_n}
  logic [2:0] q_idle, q_dcm; // filtered combinations
  logic want_one, want_dcm; // filtered mode requests
  logic ack_r; // bus answer cycle
  pmsc_pwm_if pwm ();
  assign pin_raw = {REGULATOR_ON_INPUT, SLEEP_VR_REQUEST, DEEP_STOP_N, LOW_LOAD_INDICATE_N,
                    PHASE_TWO_CURRENT_SENSE, VOUT_IN_BOOT_WINDOW, VOUT_SETTLED,
                    PHASE_ONE_ZERO_CURRENT, PHASE_TWO_ZERO_CURRENT, VOLTAGE_CODE};
  // pins cross into the core clock through two flops
  always_ff @(posedge CLK) begin
    if (RST) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end
  assign {reg_on, sleep_req, deep_n, low_load_n, ph2_tied, in_window, settled, ph1_zero, ph2_zero} =
    sync2_r[NSYNC-1:7];
  assign vcode = sync2_r[6:0];
  // decode: 1.5 v less one step per code, floored at zero
  function automatic logic [15:0] code_to_volt(input logic [6:0] code);
    logic [22:0] drop;
    drop = 23'(code) * 23'(pmsc_pkg::VSTEP_TENTH_MV);
    if (drop >= 23'(pmsc_pkg::VMAX_TENTH_MV)) begin
      code_to_volt = 16'h0;
    end else begin
      code_to_volt = 16'(23'(pmsc_pkg::VMAX_TENTH_MV) - drop);
    end
  endfunction
  // start-up sequence next state
  always_comb begin
    boot_nxt = boot_r;
    unique case (boot_r)
      pmsc_pkg::BOOT_OFF: begin
        if (reg_on) begin
          boot_nxt = pmsc_pkg::BOOT_WAIT;
        end
      end
      pmsc_pkg::BOOT_WAIT: begin
        if (dly_r >= pmsc_pkg::DLY_W'(BOOT_DELAY - 1)) begin
          boot_nxt = pmsc_pkg::BOOT_RAMP;
        end
      end
      pmsc_pkg::BOOT_RAMP: begin
        if (pwm.tick && in_window && qual_r == 4'(pmsc_pkg::QUAL_CYCLES - 1)) begin
          boot_nxt = pmsc_pkg::BOOT_PGW;
        end
      end
      pmsc_pkg::BOOT_PGW: begin
        if (dly_r >= pmsc_pkg::DLY_W'(POWER_OK_DELAY - 1)) begin
          boot_nxt = pmsc_pkg::BOOT_RUN;
        end
      end
      pmsc_pkg::BOOT_RUN: begin
        boot_nxt = pmsc_pkg::BOOT_RUN;
      end
      default: begin
        boot_nxt = pmsc_pkg::BOOT_OFF; // unused codes recover
      end
    endcase
    if (!reg_on) begin
      boot_nxt = pmsc_pkg::BOOT_OFF; // dropping the enable restarts from scratch
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      boot_r <= pmsc_pkg::BOOT_OFF;
    end else begin
      boot_r <= boot_nxt;
    end
  end
  // delay counter restarts on each state change
  always_ff @(posedge CLK) begin
    if (RST || boot_nxt != boot_r) begin
      dly_r <= '0;
    end else if (dly_r != '1) begin
      dly_r <= dly_r + 1'b1;
    end
  end
  // in-window tick count; one miss starts over
  always_ff @(posedge CLK) begin
    if (RST || boot_r != pmsc_pkg::BOOT_RAMP) begin
      qual_r <= 4'h0;
    end else if (pwm.tick) begin
      qual_r <= in_window ? qual_r + 4'h1 : 4'h0;
    end
  end
  // strap caught while off, so phase 2 never drops mid-run
  always_ff @(posedge CLK) begin
    if (RST) begin
      one_only_r <= 1'b0;
    end else if (boot_r == pmsc_pkg::BOOT_OFF) begin
      one_only_r <= ph2_tied;
    end
  end

  // code change detect and ramp tracking; a new change wins over settling
  assign code_chg = (vcode != vcode_last_r);
  always_ff @(posedge CLK) begin
    if (RST) begin
      vcode_last_r <= 7'h0;
      ramp_busy_r <= 1'b0;
    end else begin
      vcode_last_r <= vcode;
      if (code_chg) begin
        ramp_busy_r <= 1'b1;
      end else if (pwm.tick && settled) begin
        ramp_busy_r <= 1'b0;
      end
    end
  end
  // glitch filters on the control combination
  assign combo = {sleep_req, deep_n, low_load_n};
  pmsc_glitch_filter #(.PERIODS(pmsc_pkg::IDLE_FILTER)) u_idle_flt (
    .clk(CLK), .rst(RST), .tick(pwm.tick), .din(combo), .init(3'h3), .dout(q_idle)
  );
  pmsc_glitch_filter #(.PERIODS(pmsc_pkg::DCM_FILTER)) u_dcm_flt (
    .clk(CLK), .rst(RST), .tick(pwm.tick), .din(combo), .init(3'h3), .dout(q_dcm)
  );
  assign want_dcm = q_dcm[2] && !q_dcm[1];
  assign want_one = want_dcm || !q_idle[0] || (q_idle[2] && !q_idle[1]);
  // phase mode next state
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      pmsc_pkg::MODE_TWO_CCM: begin
        if (want_one && !ramp_busy_r) begin
          mode_nxt = pmsc_pkg::MODE_SHED;
        end
      end
      pmsc_pkg::MODE_SHED: begin
        if (!want_one) begin
          mode_nxt = pmsc_pkg::MODE_TWO_CCM;
        end else if (ph2_zero) begin
          mode_nxt = want_dcm ? pmsc_pkg::MODE_ONE_DCM : pmsc_pkg::MODE_ONE_CCM;
        end
      end
      pmsc_pkg::MODE_ONE_CCM: begin
        if (!want_one) begin
          mode_nxt = pmsc_pkg::MODE_TWO_CCM;
        end else if (want_dcm) begin
          mode_nxt = pmsc_pkg::MODE_ONE_DCM;
        end
      end
      pmsc_pkg::MODE_ONE_DCM: begin
        if (code_chg || !want_one) begin
          mode_nxt = pmsc_pkg::MODE_TWO_CCM;
        end else if (!want_dcm) begin
          mode_nxt = pmsc_pkg::MODE_ONE_CCM;
        end
      end
    endcase
    if (boot_r != pmsc_pkg::BOOT_RUN) begin
      mode_nxt = pmsc_pkg::MODE_TWO_CCM;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      mode_r <= pmsc_pkg::MODE_TWO_CCM;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // gate sequencer controls
  assign pwm.period = period_r;
  assign pwm.ontime = ontime_r;
  assign pwm.ph1_zero = ph1_zero;
  assign pwm.ph1_en = (boot_r == pmsc_pkg::BOOT_RAMP || boot_r == pmsc_pkg::BOOT_PGW ||
                       boot_r == pmsc_pkg::BOOT_RUN);
  // in shed phase 2 keeps switching so its current can fall to zero
  assign pwm.ph2_en = pwm.ph1_en && !one_only_r && (mode_r == pmsc_pkg::MODE_TWO_CCM ||
                                                    mode_r == pmsc_pkg::MODE_SHED);
  assign pwm.de_en = one_only_r || mode_r == pmsc_pkg::MODE_ONE_DCM;

  pmsc_gate_seq u_gates (.clk(CLK), .rst(RST), .pwm(pwm));

  // registered outputs toward the analog section
  always_ff @(posedge CLK) begin
    if (RST) begin
      SYS_CLOCK_EN_N <= 1'b1;
      POWER_OK <= 1'b0;
      SOFT_RAMP_EN <= 1'b0;
      SOFT_SRC_LOW <= 1'b0;
      SOFT_SRC_HIGH <= 1'b0;
      TARGET_TENTH_MV <= 16'h0;
      FB2_SWITCH_CLOSED <= 1'b0;
    end else begin
      SYS_CLOCK_EN_N <= !(boot_r == pmsc_pkg::BOOT_PGW || boot_r == pmsc_pkg::BOOT_RUN);
      POWER_OK <= (boot_r == pmsc_pkg::BOOT_RUN);
      SOFT_RAMP_EN <= pwm.ph1_en;
      SOFT_SRC_LOW <= (boot_r == pmsc_pkg::BOOT_RAMP);
      SOFT_SRC_HIGH <= (boot_r == pmsc_pkg::BOOT_PGW || boot_r == pmsc_pkg::BOOT_RUN);
      TARGET_TENTH_MV <= (boot_r == pmsc_pkg::BOOT_RAMP || boot_r == pmsc_pkg::BOOT_WAIT) ?
                         pmsc_pkg::VBOOT_TENTH_MV : code_to_volt(vcode);
      FB2_SWITCH_CLOSED <= !pwm.ph2_en && pwm.ph1_en;
    end
  end
  assign UGATE1 = pwm.ug1;
  assign LGATE1 = pwm.lg1;
  assign UGATE2 = pwm.ug2;
  assign LGATE2 = pwm.lg2;

  // avalon slave: one wait cycle, then the answer
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_r;
  always_ff @(posedge CLK) begin
    if (RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (AVS_READ || AVS_WRITE) && !ack_r;
    end
  end

  // writes take effect at the answer edge; a period below 2 is raised to 2 one cycle later
  always_ff @(posedge CLK) begin
    if (RST) begin
      period_r <= pmsc_pkg::PERIOD_RST;
      ontime_r <= pmsc_pkg::ONTIME_RST;
    end else if (AVS_WRITE && ack_r) begin
      if (AVS_ADDRESS == pmsc_pkg::REG_PERIOD) begin
        if (AVS_BYTEENABLE[0]) period_r[7:0] <= AVS_WRITEDATA[7:0];
        if (AVS_BYTEENABLE[1]) period_r[15:8] <= AVS_WRITEDATA[15:8];
      end else if (AVS_ADDRESS == pmsc_pkg::REG_ONTIME) begin
        if (AVS_BYTEENABLE[0]) ontime_r[7:0] <= AVS_WRITEDATA[7:0];
        if (AVS_BYTEENABLE[1]) ontime_r[15:8] <= AVS_WRITEDATA[15:8];
      end
    end else if (period_r < 16'h2) begin
      period_r <= 16'h2;
    end
  end

  // read data registered, unmapped addresses read zero
  always_ff @(posedge CLK) begin
    if (RST) begin
      AVS_READDATA <= 32'h0;
    end else if (AVS_READ && !ack_r) begin
      unique case (AVS_ADDRESS)
        pmsc_pkg::REG_PERIOD: AVS_READDATA <= {16'h0, period_r};
        pmsc_pkg::REG_ONTIME: AVS_READDATA <= {16'h0, ontime_r};
        pmsc_pkg::REG_STATUS: begin
          AVS_READDATA <= 32'h0;
          AVS_READDATA[pmsc_pkg::ST_BOOT_LSB +: 3] <= boot_r;
          AVS_READDATA[pmsc_pkg::ST_MODE_LSB +: 2] <= mode_r;
          AVS_READDATA[pmsc_pkg::ST_CLKEN_N] <= SYS_CLOCK_EN_N;
          AVS_READDATA[pmsc_pkg::ST_POK] <= POWER_OK;
          AVS_READDATA[pmsc_pkg::ST_ONEPH] <= one_only_r;
          AVS_READDATA[pmsc_pkg::ST_RAMP] <= ramp_busy_r;
          AVS_READDATA[pmsc_pkg::ST_VCODE_LSB +: 7] <= vcode;
        end
        pmsc_pkg::REG_TARGET: AVS_READDATA <= {16'h0, TARGET_TENTH_MV};
        default: AVS_READDATA <= 32'h0;
      endcase
    end
  end
endmodule

// ---- hw/pmsc_pkg.sv ----
/*
  constants, register map and state types of the mode and start-up block.
  assumes a 100 MHz core clock.
*/
package pmsc_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 10; // 100 mhz core clock
  // start-up timing
  localparam int BOOT_DELAY_NS = 100000; // enable to boot ramp, 100 us
  localparam int POWER_OK_DELAY_NS = 7000000; // clock enable to power ok (7 ms)
  localparam int BOOT_DELAY_CYC = BOOT_DELAY_NS / CLK_PERIOD_NS;
  localparam int POWER_OK_DELAY_CYC = POWER_OK_DELAY_NS / CLK_PERIOD_NS;
  localparam int DLY_W = 24; // width of the start-up delay counter
  // switching-cycle counts
  localparam int QUAL_CYCLES = 13; // in-window cycles before clock enable
  localparam int IDLE_FILTER = 2; // periods before a phase is idled
  localparam int DCM_FILTER = 7; // periods before diode emulation
  // voltage code decode, units of 0.1 mv
  localparam logic [15:0] VMAX_TENTH_MV = 16'h3a98; // 1.5000 v at code zero
  localparam logic [15:0] VSTEP_TENTH_MV = 16'h007d; // 12.5 mv per code step
  localparam logic [15:0] VBOOT_TENTH_MV = 16'h2ee0; // 1.2 v boot target
  // switching period, in core cycles
  localparam logic [15:0] PERIOD_RST = 16'h014d; // 333 cycles, about 300 khz
  localparam logic [15:0] ONTIME_RST = 16'h0042; // upper-gate on time
  // register map, byte addresses
  localparam logic [4:0] REG_PERIOD = 5'h00; // rw switching period
  localparam logic [4:0] REG_ONTIME = 5'h04; // rw upper-gate on time
  localparam logic [4:0] REG_STATUS = 5'h08; // ro state and pins
  localparam logic [4:0] REG_TARGET = 5'h0c; // ro decoded target voltage
  // status field positions
  localparam int ST_BOOT_LSB = 0; // 3-bit start-up state
  localparam int ST_MODE_LSB = 4; // 2-bit phase mode
  localparam int ST_CLKEN_N = 8; // clock enable output, active low
  localparam int ST_POK = 9; // power ok output
  localparam int ST_ONEPH = 10; // single-phase-only strap
  localparam int ST_RAMP = 11; // voltage ramp in progress
  localparam int ST_VCODE_LSB = 16; // synchronised voltage code
  // start-up states, gray along the path
  typedef enum logic [2:0] {
    BOOT_OFF = 3'h0,
    BOOT_WAIT = 3'h1,
    BOOT_RAMP = 3'h3,
    BOOT_PGW = 3'h2,
    BOOT_RUN = 3'h6
  } pmsc_boot_t;
  // phase modes, gray around the ring
  typedef enum logic [1:0] {
    MODE_TWO_CCM = 2'h0,
    MODE_SHED = 2'h1,
    MODE_ONE_CCM = 2'h3,
    MODE_ONE_DCM = 2'h2
  } pmsc_mode_t;
endpackage

// ---- hw/pmsc_pwm_if.sv ----
/*
  mode controller to gate sequencer signals.
  assumes one core clock at both ends.
*/
`timescale 1ns/1ps
interface pmsc_pwm_if;
  logic [15:0] period; // switching period in core cycles
  logic [15:0] ontime; // upper-gate on time in core cycles
  logic ph1_en; // phase 1 may switch
  logic ph2_en; // phase 2 may switch
  logic de_en; // diode emulation on phase 1
  logic ph1_zero; // phase 1 current at zero, synchronised
  logic tick; // one pulse per switching period
  logic ug1; // phase 1 upper gate
  logic lg1; // phase 1 lower gate
  logic ug2; // phase 2 upper gate
  logic lg2; // phase 2 lower gate
  modport ctl (output period, ontime, ph1_en, ph2_en, de_en, ph1_zero, input tick, ug1, lg1, ug2, lg2);
  modport drv (input period, ontime, ph1_en, ph2_en, de_en, ph1_zero, output tick, ug1, lg1, ug2, lg2);
endinterface

// ---- hw/pmsc_glitch_filter.sv ----
/*
  passes a power-state combination on once stable for whole periods.
  assumes synchronised inputs and a one-cycle period tick.
*/
`timescale 1ns/1ps
module pmsc_glitch_filter #(
  parameter int PERIODS = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [2:0] din,
  input wire logic [2:0] init,
  output logic [2:0] dout
);
  logic [2:0] last_r; // combination seen last cycle
  logic [3:0] cnt_r; // whole periods the combination has held
  localparam logic [3:0] LIMIT = 4'(PERIODS + 1); // one extra tick: a burst may straddle a tick

  // restart the count whenever the combination changes
  always_ff @(posedge clk) begin
    if (rst) begin
      last_r <= 3'h0;
      cnt_r <= 4'h0;
    end else if (din != last_r) begin
      last_r <= din;
      cnt_r <= 4'h0;
    end else if (tick && cnt_r != LIMIT) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // pass the combination once it has lasted the full count
  always_ff @(posedge clk) begin
    if (rst) begin
      dout <= init; // idle value before any stable combination
    end else if (din == last_r && cnt_r == LIMIT) begin
      dout <= last_r;
    end
  end
endmodule

// ---- hw/pmsc_gate_seq.sv ----
/*
  two-phase gate sequencer: period counter, interleaving, idle and
  diode-emulation gating. assumes a period of at least 2.
*/
`timescale 1ns/1ps
module pmsc_gate_seq (
  input wire logic clk,
  input wire logic rst,
  pmsc_pwm_if.drv pwm
);
  logic [15:0] cnt_r; // position inside the switching period
  logic [15:0] cnt2; // phase 2 position, half a period later
  logic [16:0] sum2; // unwrapped phase 2 position
  logic zero_seen_r; // phase 1 current reached zero this period

  // period counter and tick
  always_ff @(posedge clk) begin
    if (rst || cnt_r >= pwm.period - 16'h1) begin
      cnt_r <= 16'h0;
    end else begin
      cnt_r <= cnt_r + 16'h1;
    end
  end
  assign pwm.tick = (cnt_r == 16'h0);

  // phase 2 runs half a period behind phase 1
  always_comb begin
    sum2 = {1'b0, cnt_r} + {2'b00, pwm.period[15:1]};
    cnt2 = (sum2 >= {1'b0, pwm.period}) ? 16'(sum2 - {1'b0, pwm.period}) : sum2[15:0];
  end

  // in diode emulation, after zero current the phase 1 lower gate stays off till period end
  always_ff @(posedge clk) begin
    if (rst || pwm.tick) begin
      zero_seen_r <= 1'b0;
    end else if (pwm.ph1_zero) begin
      zero_seen_r <= 1'b1;
    end
  end

  // gate registers; an idled phase holds both gates off
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm.ug1 <= 1'b0;
      pwm.lg1 <= 1'b0;
      pwm.ug2 <= 1'b0;
      pwm.lg2 <= 1'b0;
    end else begin
      pwm.ug1 <= pwm.ph1_en && cnt_r < pwm.ontime;
      pwm.lg1 <= pwm.ph1_en && cnt_r >= pwm.ontime && !(pwm.de_en && (zero_seen_r || pwm.ph1_zero));
      pwm.ug2 <= pwm.ph2_en && cnt2 < pwm.ontime;
      pwm.lg2 <= pwm.ph2_en && cnt2 >= pwm.ontime;
    end
  end
endmodule

// ---- testbench/pmsc_startup_properties.sv ----
/* start-up checks on the top ports.
   assumes one clock and a synchronous reset. */
`timescale 1ns/1ps
module pmsc_startup_properties #(
  parameter int BOOT_DELAY = 20,
  parameter int POWER_OK_DELAY = 200
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic REGULATOR_ON_INPUT,
  input wire logic [6:0] VOLTAGE_CODE,
  input wire logic SYS_CLOCK_EN_N,
  input wire logic POWER_OK,
  input wire logic SOFT_RAMP_EN,
  input wire logic SOFT_SRC_LOW,
  input wire logic SOFT_SRC_HIGH,
  input wire logic [15:0] TARGET_TENTH_MV
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  int on_cnt_r; // cycles the enable pin has been high
  int low_cnt_r; // cycles the clock enable has been active
  // long delays are counted, not repeated
  always_ff @(posedge CLK) begin
    on_cnt_r <= (RST || !REGULATOR_ON_INPUT) ? 0 : on_cnt_r + 1;
    low_cnt_r <= (RST || SYS_CLOCK_EN_N) ? 0 : low_cnt_r + 1;
  end
  // code to 0.1 mv, zero above code 120
  function automatic logic [15:0] code_mv(input logic [6:0] c);
    code_mv = (c > 7'h78) ? 16'h0000 : 16'h3a98 - 16'h007d * {9'h000, c};
  endfunction
  AST_RAMP_DELAY: assert property ($rose(SOFT_RAMP_EN) |-> on_cnt_r inside {[BOOT_DELAY+1:BOOT_DELAY+8]})
    else $error("ramp start time");
  AST_BOOT_TARGET: assert property (SOFT_SRC_LOW |-> TARGET_TENTH_MV == 16'h2ee0)
    else $error("boot target");
  AST_SRC_EXCL: assert property (!(SOFT_SRC_LOW && SOFT_SRC_HIGH))
    else $error("both soft sources on");
  AST_CLKEN_SRC: assert property ($fell(SYS_CLOCK_EN_N) |-> SOFT_SRC_HIGH && $past(SOFT_SRC_LOW))
    else $error("no source swap");
  AST_POK_DELAY: assert property ($rose(POWER_OK) |-> low_cnt_r inside {[POWER_OK_DELAY-1:POWER_OK_DELAY+3]})
    else $error("power ok delay wrong");
  AST_POK_CLKEN: assert property (POWER_OK |-> !SYS_CLOCK_EN_N)
    else $error("power ok early");
  AST_TARGET: assert property ((POWER_OK && REGULATOR_ON_INPUT && $stable(VOLTAGE_CODE))[*6]
    |-> TARGET_TENTH_MV == code_mv(VOLTAGE_CODE))
    else $error("decoded target wrong");
  AST_OFF: assert property ($fell(REGULATOR_ON_INPUT) |-> ##[1:6] (!POWER_OK && SYS_CLOCK_EN_N && !SOFT_RAMP_EN))
    else $error("disable ignored");
  AST_RAMP_ON: assert property ($rose(SOFT_RAMP_EN) |-> REGULATOR_ON_INPUT)
    else $error("ramp while off");
endmodule
bind pmsc_startup_top pmsc_startup_properties #(.BOOT_DELAY(BOOT_DELAY), .POWER_OK_DELAY(POWER_OK_DELAY)) u_props (.*);

// ---- testbench/pmsc_host_model.sv ----
/* host side: power-state pins, voltage code and comparator levels.
   assumes the bench picks each combination. */
`timescale 1ns/1ps
module pmsc_host_model (
  input wire logic clk,
  input wire logic [2:0] combo,
  input wire logic [6:0] code,
  input wire logic lg1,
  input wire logic lg2,
  output logic sleep_vr_request,
  output logic deep_stop_n,
  output logic low_load_indicate_n,
  output logic [6:0] voltage_code,
  output logic vout_settled,
  output logic ph1_zero,
  output logic ph2_zero
);
  int still_r; // cycles the code has been unchanged
  initial begin
    {sleep_vr_request, deep_stop_n, low_load_indicate_n} = 3'h3;
    {voltage_code, vout_settled, ph1_zero, ph2_zero} = 10'h000;
    still_r = 0;
  end
  // pins move right after the edge
  always @(posedge clk) begin
    sleep_vr_request <= combo[2];
    deep_stop_n <= combo[1];
    low_load_indicate_n <= combo[0];
    voltage_code <= code;
    still_r <= (code != voltage_code) ? 0 : still_r + 1;
    // slow settling keeps a code ramp busy
    vout_settled <= (still_r > 100);
    // zero current once the lower gate conducted
    ph1_zero <= lg1;
    ph2_zero <= lg2;
  end
endmodule

// ---- testbench/tb_top.sv ----
/* self-checking bench of the start-up and mode block.
   assumes short delays and a 10-cycle period. */
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, avs_read, avs_write, avs_wait;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic reg_on, strap, window; // enable pin, phase two strap, boot window
  logic [2:0] combo; // sleep request, deep stop, load indicator
  logic [6:0] code, vcode;
  logic slp, dstop_n, load_n, settled, zero1, zero2;
  logic clken_n, pok, ramp_en, src_lo, src_hi, ug1, lg1, ug2, lg2;
  logic [15:0] target;
  int bad_count, compares, cyc;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  pmsc_startup_top #(.BOOT_DELAY(20), .POWER_OK_DELAY(200)) u_pmsc_startup_top (.CLK(clk), .RST(rst),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(4'h3), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_wait),
    .REGULATOR_ON_INPUT(reg_on), .SLEEP_VR_REQUEST(slp), .DEEP_STOP_N(dstop_n), .LOW_LOAD_INDICATE_N(load_n),
    .VOLTAGE_CODE(vcode), .PHASE_TWO_CURRENT_SENSE(strap), .VOUT_IN_BOOT_WINDOW(window),
    .VOUT_SETTLED(settled), .PHASE_ONE_ZERO_CURRENT(zero1), .PHASE_TWO_ZERO_CURRENT(zero2),
    .SYS_CLOCK_EN_N(clken_n), .POWER_OK(pok), .SOFT_RAMP_EN(ramp_en), .SOFT_SRC_LOW(src_lo),
    .SOFT_SRC_HIGH(src_hi), .TARGET_TENTH_MV(target), .FB2_SWITCH_CLOSED(), .UGATE1(ug1), .LGATE1(lg1),
    .UGATE2(ug2), .LGATE2(lg2));
  pmsc_host_model u_pmsc_host_model (.clk(clk), .combo(combo), .code(code), .lg1(lg1), .lg2(lg2),
    .sleep_vr_request(slp), .deep_stop_n(dstop_n), .low_load_indicate_n(load_n), .voltage_code(vcode),
    .vout_settled(settled), .ph1_zero(zero1), .ph2_zero(zero2));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  // hold the request until waitrequest is low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_wait !== 1'b0 && n < 50);
    if (avs_wait !== 1'b0) bad_count++;
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (s !== v) bad_count++;
  endtask
  // let the inputs act, then read the mode
  task automatic mode_is(input int w, input logic [1:0] m, input string msg);
    repeat (w) @(posedge clk);
    bus(1'b0, pmsc_pkg::REG_STATUS, 32'h0);
    chk(d[5:4], m, msg);
  endtask
  // phase two gates counted over six periods
  task automatic p2_quiet(input logic exp);
    int n, o;
    n = 0;
    o = 0;
    repeat (60) @(posedge clk) begin
      n += (ug2 | lg2);
      o += (ug1 & ug2);
    end
    chk(n == 0, exp, "p2 gates");
    chk(o, 0, "upper gates overlap");
  endtask
  task automatic t_regs;
    bus(1'b0, pmsc_pkg::REG_PERIOD, 0);
    chk(d, 32'h14d, "period reset");
    bus(1'b0, pmsc_pkg::REG_ONTIME, 0);
    chk(d, 32'h42, "on time reset");
    bus(1'b1, 5'h10, 32'hffff_ffff);
    bus(1'b0, 5'h10, 0);
    chk(d, 32'h0, "unmapped read");
    bus(1'b1, pmsc_pkg::REG_PERIOD, 32'h0a);
    bus(1'b1, pmsc_pkg::REG_ONTIME, 32'h03);
    bus(1'b0, pmsc_pkg::REG_PERIOD, 0);
    chk(d, 32'h0a, "period write");
    bus(1'b0, pmsc_pkg::REG_STATUS, 0);
    chk(d[9:8], 2'h1, "status at rest");
    $display("test regs done");
  endtask
  task automatic t_start;
    combo <= 3'h4;
    reg_on <= 1'b1;
    wait_lvl(src_lo, 1'b1);
    chk(target, 16'h2ee0, "boot target");
    window <= 1'b1;
    repeat (100) @(posedge clk);
    chk(clken_n, 1'b1, "clken early");
    wait_lvl(clken_n, 1'b0);
    chk(src_hi, 1'b1, "fast source");
    mode_is(0, pmsc_pkg::MODE_TWO_CCM, "start-up mode");
    wait_lvl(pok, 1'b1);
    chk(pok, 1'b1, "power ok");
    $display("test start done");
  endtask
  task automatic t_modes;
    logic [1:0] m;
    for (int i = 0; i < 8; i++) begin
      combo <= i[2:0];
      m = (i[2] && !i[1]) ? pmsc_pkg::MODE_ONE_DCM : (i[0] ? pmsc_pkg::MODE_TWO_CCM : pmsc_pkg::MODE_ONE_CCM);
      mode_is(200, m, "mode table");
      p2_quiet(m != pmsc_pkg::MODE_TWO_CCM);
    end
    combo <= 3'h3;
    mode_is(200, pmsc_pkg::MODE_TWO_CCM, "two phase");
    $display("test modes done");
  endtask
  task automatic t_glitch;
    combo <= 3'h2;
    repeat (15) @(posedge clk);
    combo <= 3'h3;
    mode_is(100, pmsc_pkg::MODE_TWO_CCM, "short load pulse");
    combo <= 3'h4;
    repeat (60) @(posedge clk);
    combo <= 3'h3;
    bus(1'b0, pmsc_pkg::REG_STATUS, 0);
    chk(d[5:4] == pmsc_pkg::MODE_ONE_DCM, 1'b0, "short sleep pulse");
    mode_is(300, pmsc_pkg::MODE_TWO_CCM, "recovered");
    $display("test glitch done");
  endtask
  task automatic t_code;
    logic [6:0] c[4] = '{7'h00, 7'h01, 7'h60, 7'h7f};
    logic [15:0] v[4] = '{16'h3a98, 16'h3a1b, 16'h0bb8, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      code <= c[i];
      repeat (20) @(posedge clk);
      chk(target, v[i], "code decode");
    end
    code <= 7'h10;
    combo <= 3'h2;
    mode_is(40, pmsc_pkg::MODE_TWO_CCM, "shed during ramp");
    mode_is(200, pmsc_pkg::MODE_ONE_CCM, "shed after ramp");
    combo <= 3'h4;
    mode_is(300, pmsc_pkg::MODE_ONE_DCM, "diode emulation");
    code <= 7'h11;
    mode_is(5, pmsc_pkg::MODE_TWO_CCM, "code change exit");
    combo <= 3'h3;
    $display("test code done");
  endtask
  task automatic t_strap;
    reg_on <= 1'b0;
    repeat (10) @(posedge clk);
    chk({pok, clken_n}, 2'h1, "disable");
    strap <= 1'b1;
    repeat (5) @(posedge clk);
    reg_on <= 1'b1;
    wait_lvl(pok, 1'b1);
    bus(1'b0, pmsc_pkg::REG_STATUS, 0);
    chk(d[10], 1'b1, "strap seen");
    p2_quiet(1'b1);
    $display("test strap done");
  endtask
  task automatic end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog: the full run needs about 4300 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      end_sim;
    end
  end
  initial begin
    {rst, avs_read, avs_write, avs_address, avs_writedata} = {3'h4, 37'h0};
    {reg_on, strap, window, combo, code} = {6'h03, 7'h10};
    {bad_count, compares, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_start;
    t_modes;
    t_glitch;
    t_code;
    t_strap;
    end_sim;
  end
endmodule
